// ===== src/muldiv_map.vh
// command codes, result reset value and interlock counts of the multiply/divide unit
`ifndef MULDIV_MAP_VH
`define MULDIV_MAP_VH
`define OP_NONE                 4'h0
`define OP_SIGNED_WORD_PRODUCT  4'h1
`define OP_UNSIGNED_WORD_PROD   4'h2
`define OP_SIGNED_WORD_QUOT     4'h3
`define OP_UNSIGNED_WORD_QUOT   4'h4
`define OP_SIGNED_DWORD_PRODUCT 4'h5
`define OP_UNSIGNED_DWORD_PROD  4'h6
`define OP_SIGNED_DWORD_QUOT    4'h7
`define OP_UNSIGNED_DWORD_QUOT  4'h8
`define OP_WORD_HALF_ACC        4'h9
`define OP_DWORD_HALF_ACC       4'hA
`define OP_READ_UPPER_MOVE      4'hB
`define OP_READ_BOTTOM_MOVE     4'hC
`define OP_WRITE_UPPER_MOVE     4'hD
`define OP_WRITE_BOTTOM_MOVE    4'hE
`define STALL_WORD_MUL          7'h01
`define STALL_WORD_DIV          7'h23
`define STALL_DWORD_MUL         7'h04
`define STALL_DWORD_DIV         7'h43
`define STALL_HALF_ACC          7'h01
`define RESULT_RESET            64'h0000000000000000
`endif

// ===== src/muldiv_unit.v
// integer multiply/divide unit with upper and bottom result registers
`timescale 1ns/1ps
`include "muldiv_map.vh"

module muldiv_unit (
  input  wire        CLOCK_IN,
  input  wire        RST_IN,
  input  wire        ISSUE_IN,
  input  wire [3:0]  OP_IN,
  input  wire [63:0] SOURCE_A_OPERAND_IN,
  input  wire [63:0] SOURCE_B_OPERAND_IN,
  output reg         STALL_OUT,
  output reg         READ_VALID_OUT,
  output reg  [63:0] READ_DATA_OUT,
  output reg  [63:0] UPPER_RESULT_OUT,
  output reg  [63:0] BOTTOM_RESULT_OUT
);

  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;

  // state, count, results and the held read
  reg          state_ff;
  reg  [6:0]   count_ff;
  reg  [63:0]  upper_result_reg_ff;
  reg  [63:0]  bottom_result_reg_ff;
  reg  [63:0]  pend_upper_ff;
  reg  [63:0]  pend_bottom_ff;
  reg          held_read_ff;
  reg          held_upper_ff;

  // next values of registers and outputs
  reg          nxt_state;
  reg  [6:0]   nxt_count;
  reg  [63:0]  nxt_upper;
  reg  [63:0]  nxt_bottom;
  reg  [63:0]  nxt_pend_upper;
  reg  [63:0]  nxt_pend_bottom;
  reg          nxt_held_read;
  reg          nxt_held_upper;
  reg          nxt_stall;
  reg          nxt_read_valid;
  reg  [63:0]  nxt_read_data;

  // word operands, signed and unsigned views
  wire signed [31:0]  a_w_s = SOURCE_A_OPERAND_IN[31:0];
  wire signed [31:0]  b_w_s = SOURCE_B_OPERAND_IN[31:0];
  wire        [31:0]  a_w_u = SOURCE_A_OPERAND_IN[31:0];
  wire        [31:0]  b_w_u = SOURCE_B_OPERAND_IN[31:0];

  // dword operands as signed values
  wire signed [63:0]  a_d_s = SOURCE_A_OPERAND_IN;
  wire signed [63:0]  b_d_s = SOURCE_B_OPERAND_IN;

  // half operands for the accumulates
  wire signed [15:0]  a_h_s = SOURCE_A_OPERAND_IN[15:0];
  wire signed [15:0]  b_h_s = SOURCE_B_OPERAND_IN[15:0];

  // word products
  wire signed [63:0]  wmul_s = a_w_s * b_w_s;
  wire        [63:0]  wmul_u = a_w_u * b_w_u;

  // dword products, 128 bits wide
  wire signed [127:0] dmul_s = {{64{a_d_s[63]}}, a_d_s}
                             * {{64{b_d_s[63]}}, b_d_s};
  // unsigned form zero-extends both operands
  wire        [127:0] dmul_u = {64'h0, SOURCE_A_OPERAND_IN}
                             * {64'h0, SOURCE_B_OPERAND_IN};

  // half products sign-extended to 64 bits
  wire signed [31:0]  hmul   = a_h_s * b_h_s;
  wire        [63:0]  hmul64 = {{32{hmul[31]}}, hmul};

  // divider zero guard keeps simulation free of unknowns
  wire                wb_zero = (b_w_u == 32'h0);
  wire                db_zero = (SOURCE_B_OPERAND_IN == 64'h0);

  // divisors with zero replaced by one
  wire signed [31:0]  wdiv_bs = wb_zero ? 32'sh1 : b_w_s;
  wire        [31:0]  wdiv_bu = wb_zero ? 32'h1 : b_w_u;
  wire signed [63:0]  signed_dword_quotient_bs = db_zero ? 64'sh1 : b_d_s;
  wire        [63:0]  signed_dword_quotient_bu = db_zero ? 64'h1 : SOURCE_B_OPERAND_IN;

  // word quotients and remainders
  wire signed [31:0]  wq_s = a_w_s / wdiv_bs;
  wire signed [31:0]  wr_s = a_w_s % wdiv_bs;
  wire        [31:0]  wq_u = a_w_u / wdiv_bu;
  wire        [31:0]  wr_u = a_w_u % wdiv_bu;

  // dword quotients and remainders
  wire signed [63:0]  dq_s = a_d_s / signed_dword_quotient_bs;
  wire signed [63:0]  dr_s = a_d_s % signed_dword_quotient_bs;
  wire        [63:0]  dq_u = SOURCE_A_OPERAND_IN / signed_dword_quotient_bu;
  wire        [63:0]  dr_u = SOURCE_A_OPERAND_IN % signed_dword_quotient_bu;

  // accumulates against the architectural registers
  wire        [63:0]  pair_acc = {upper_result_reg_ff[31:0],
                                  bottom_result_reg_ff[31:0]}
                               + hmul64;

  // dword accumulate on the bottom register alone
  wire        [63:0]  low_acc  = bottom_result_reg_ff + hmul64;

  // sign-extend a word to 64 bits
  function [63:0] sext32;
    input [31:0] v;
    begin
      sext32 = {{32{v[31]}}, v};
    end
  endfunction

  // classify commands that start a pending operation
  function is_arith;
    input [3:0] op;
    begin
      is_arith = (op >= `OP_SIGNED_WORD_PRODUCT) &&
                 (op <= `OP_DWORD_HALF_ACC);
    end
  endfunction

  // result read commands
  function is_read_op;
    input [3:0] op;
    begin
      is_read_op = (op == `OP_READ_UPPER_MOVE) ||
                   (op == `OP_READ_BOTTOM_MOVE);
    end
  endfunction

  // read commands that return the upper register
  function is_upper_read;
    input [3:0] op;
    begin
      is_upper_read = (op == `OP_READ_UPPER_MOVE);
    end
  endfunction

  wire is_read = is_read_op(OP_IN);

  // register that a released read returns
  wire release_upper = held_read_ff ? held_upper_ff : is_upper_read(OP_IN);

  // next state, result and interlock logic
  always @* begin
    // hold every register unless a command changes it
    nxt_state       = state_ff;
    nxt_count       = count_ff;
    nxt_upper       = upper_result_reg_ff;
    nxt_bottom      = bottom_result_reg_ff;
    nxt_pend_upper  = pend_upper_ff;
    nxt_pend_bottom = pend_bottom_ff;
    nxt_held_read   = held_read_ff;
    nxt_held_upper  = held_upper_ff;
    // output strobes default to idle
    nxt_stall       = 1'b0;
    nxt_read_valid  = 1'b0;
    nxt_read_data   = READ_DATA_OUT;
    case (state_ff)
      ST_IDLE: begin
        if (ISSUE_IN) begin
          case (OP_IN)
            // idle reads answer on the next edge
            `OP_READ_UPPER_MOVE: begin
              nxt_read_valid = 1'b1;
              nxt_read_data  = upper_result_reg_ff;
            end
            `OP_READ_BOTTOM_MOVE: begin
              nxt_read_valid = 1'b1;
              nxt_read_data  = bottom_result_reg_ff;
            end

            // writes load a register directly
            `OP_WRITE_UPPER_MOVE:
              nxt_upper = SOURCE_A_OPERAND_IN;
            `OP_WRITE_BOTTOM_MOVE:
              nxt_bottom = SOURCE_A_OPERAND_IN;
            default: ;
          endcase

          // arithmetic results are held back until the count expires
          if (is_arith(OP_IN)) begin
            nxt_state = ST_BUSY;
            case (OP_IN)
              // signed word product
              `OP_SIGNED_WORD_PRODUCT: begin
                nxt_pend_upper  = sext32(wmul_s[63:32]);
                nxt_pend_bottom = sext32(wmul_s[31:0]);
                nxt_count       = `STALL_WORD_MUL;
              end

              // unsigned word product
              `OP_UNSIGNED_WORD_PROD: begin
                nxt_pend_upper  = sext32(wmul_u[63:32]);
                nxt_pend_bottom = sext32(wmul_u[31:0]);
                nxt_count       = `STALL_WORD_MUL;
              end

              // signed word quotient
              `OP_SIGNED_WORD_QUOT: begin
                nxt_pend_upper  = sext32(wr_s);
                nxt_pend_bottom = sext32(wq_s);
                nxt_count       = `STALL_WORD_DIV;
              end

              // unsigned word quotient
              `OP_UNSIGNED_WORD_QUOT: begin
                nxt_pend_upper  = sext32(wr_u);
                nxt_pend_bottom = sext32(wq_u);
                nxt_count       = `STALL_WORD_DIV;
              end

              // signed dword product
              `OP_SIGNED_DWORD_PRODUCT: begin
                nxt_pend_upper  = dmul_s[127:64];
                nxt_pend_bottom = dmul_s[63:0];
                nxt_count       = `STALL_DWORD_MUL;
              end

              // unsigned dword product
              `OP_UNSIGNED_DWORD_PROD: begin
                nxt_pend_upper  = dmul_u[127:64];
                nxt_pend_bottom = dmul_u[63:0];
                nxt_count       = `STALL_DWORD_MUL;
              end

              // signed dword quotient
              `OP_SIGNED_DWORD_QUOT: begin
                nxt_pend_upper  = dr_s;
                nxt_pend_bottom = dq_s;
                nxt_count       = `STALL_DWORD_DIV;
              end

              // unsigned dword quotient
              `OP_UNSIGNED_DWORD_QUOT: begin
                nxt_pend_upper  = dr_u;
                nxt_pend_bottom = dq_u;
                nxt_count       = `STALL_DWORD_DIV;
              end

              // word half accumulate on the register pair
              `OP_WORD_HALF_ACC: begin
                nxt_pend_upper  = sext32(pair_acc[63:32]);
                nxt_pend_bottom = sext32(pair_acc[31:0]);
                nxt_count       = `STALL_HALF_ACC;
              end

              // dword half accumulate, upper untouched
              default: begin
                nxt_pend_upper  = upper_result_reg_ff;
                nxt_pend_bottom = low_acc;
                nxt_count       = `STALL_HALF_ACC;
              end
            endcase
          end
        end
      end

      ST_BUSY: begin
        // a result read waits; other commands are dropped while busy
        if (ISSUE_IN && is_read && !held_read_ff) begin
          nxt_held_read  = 1'b1;
          nxt_held_upper = is_upper_read(OP_IN);
        end
        // completing edge commits the pending results
        if (count_ff == 7'h01) begin
          nxt_state  = ST_IDLE;
          nxt_count  = 7'h00;
          nxt_upper  = pend_upper_ff;
          nxt_bottom = pend_bottom_ff;
          // release a held read with the fresh value
          if (held_read_ff || (ISSUE_IN && is_read)) begin
            nxt_held_read  = 1'b0;
            nxt_read_valid = 1'b1;
            nxt_read_data  = release_upper ? pend_upper_ff :
                                             pend_bottom_ff;
          end
        end else begin
          // still counting; a waiting read stalls
          nxt_count = count_ff - 7'h01;
          nxt_stall = held_read_ff || (ISSUE_IN && is_read);
        end
      end

      default: nxt_state = ST_IDLE;
    endcase
  end

  // state registers
  always @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      // architectural state
      state_ff             <= ST_IDLE;
      count_ff             <= 7'h00;
      upper_result_reg_ff  <= `RESULT_RESET;
      bottom_result_reg_ff <= `RESULT_RESET;
      pend_upper_ff        <= `RESULT_RESET;
      pend_bottom_ff       <= `RESULT_RESET;
      held_read_ff         <= 1'b0;
      held_upper_ff        <= 1'b0;
      // output flops
      STALL_OUT            <= 1'b0;
      READ_VALID_OUT       <= 1'b0;
      READ_DATA_OUT        <= `RESULT_RESET;
      UPPER_RESULT_OUT     <= `RESULT_RESET;
      BOTTOM_RESULT_OUT    <= `RESULT_RESET;
    end else begin
      // architectural state
      state_ff             <= nxt_state;
      count_ff             <= nxt_count;
      upper_result_reg_ff  <= nxt_upper;
      bottom_result_reg_ff <= nxt_bottom;
      pend_upper_ff        <= nxt_pend_upper;
      pend_bottom_ff       <= nxt_pend_bottom;
      held_read_ff         <= nxt_held_read;
      held_upper_ff        <= nxt_held_upper;
      // output flops
      STALL_OUT            <= nxt_stall;
      READ_VALID_OUT       <= nxt_read_valid;
      READ_DATA_OUT        <= nxt_read_data;
      UPPER_RESULT_OUT     <= nxt_upper;
      BOTTOM_RESULT_OUT    <= nxt_bottom;
    end
  end

endmodule // muldiv_unit

// ===== sim/muldiv_unit_asserts.sv
// concurrent checks on the multiply/divide unit ports
`timescale 1ns/1ps
`include "muldiv_map.vh"
module muldiv_unit_asserts (
  input wire        CLOCK_IN,
  input wire        RST_IN,
  input wire        ISSUE_IN,
  input wire [3:0]  OP_IN,
  input wire [63:0] SOURCE_A_OPERAND_IN,
  input wire [63:0] SOURCE_B_OPERAND_IN,
  input wire        STALL_OUT,
  input wire        READ_VALID_OUT,
  input wire [63:0] READ_DATA_OUT,
  input wire [63:0] UPPER_RESULT_OUT,
  input wire [63:0] BOTTOM_RESULT_OUT
);
  reg  [6:0]  cnt_ff;
  reg  [6:0]  nxt_cnt;
  reg         held_ff;
  reg         up_ff;
  wire        free = ISSUE_IN && cnt_ff == 7'h00;
  wire        rd = OP_IN == `OP_READ_UPPER_MOVE ||
                   OP_IN == `OP_READ_BOTTOM_MOVE;
  wire [63:0] wprod = {{32{SOURCE_A_OPERAND_IN[31]}},
                       SOURCE_A_OPERAND_IN[31:0]}
                    * {{32{SOURCE_B_OPERAND_IN[31]}},
                       SOURCE_B_OPERAND_IN[31:0]};
  // countdown of the pending operation
  always @* begin
    nxt_cnt = (cnt_ff != 7'h00) ? cnt_ff - 7'h01 : 7'h00;
    if (free && OP_IN >= 4'h1 && OP_IN <= 4'hA) begin
      nxt_cnt = (OP_IN == 4'h3 || OP_IN == 4'h4) ? `STALL_WORD_DIV :
                (OP_IN == 4'h5 || OP_IN == 4'h6) ? `STALL_DWORD_MUL :
                (OP_IN == 4'h7 || OP_IN == 4'h8) ? `STALL_DWORD_DIV :
                `STALL_WORD_MUL;
    end
  end
  // a result read waiting on the pending operation
  always @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      cnt_ff  <= 7'h00;
      held_ff <= 1'b0;
      up_ff   <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      if (ISSUE_IN && rd && cnt_ff > 7'h01 && !held_ff) begin
        held_ff <= 1'b1;
        up_ff   <= OP_IN == `OP_READ_UPPER_MOVE;
      end else if (cnt_ff == 7'h01) begin
        held_ff <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  sequence s_mul; free && OP_IN == `OP_SIGNED_WORD_PRODUCT; endsequence
  sequence s_rdu; free && OP_IN == `OP_READ_UPPER_MOVE; endsequence
  sequence s_rdb; free && OP_IN == `OP_READ_BOTTOM_MOVE; endsequence
  sequence s_wru; free && OP_IN == `OP_WRITE_UPPER_MOVE; endsequence
  sequence s_wrb; free && OP_IN == `OP_WRITE_BOTTOM_MOVE; endsequence
  sequence s_last; held_ff && cnt_ff == 7'h01; endsequence
  AST_WORD_PRODUCT: assert property (s_mul |=> ##1
    {UPPER_RESULT_OUT[31:0], BOTTOM_RESULT_OUT[31:0]} == $past(wprod, 2))
    else $error("word product wrong after completion");
  AST_HOLD_PENDING: assert property (cnt_ff > 7'h01 |=>
    $stable(UPPER_RESULT_OUT) && $stable(BOTTOM_RESULT_OUT))
    else $error("result changed before the operation finished");
  AST_STALL_HELD: assert property (held_ff && cnt_ff != 7'h00 |-> STALL_OUT)
    else $error("held read without stall");
  AST_STALL_IDLE: assert property (cnt_ff == 7'h00 |-> !STALL_OUT)
    else $error("stall with nothing pending");
  AST_NO_EARLY: assert property (held_ff && cnt_ff > 7'h01 |=> !READ_VALID_OUT)
    else $error("held read answered early");
  AST_HELD_DONE: assert property (s_last |=> READ_VALID_OUT &&
    READ_DATA_OUT == (up_ff ? UPPER_RESULT_OUT : BOTTOM_RESULT_OUT))
    else $error("held read not answered at completion");
  AST_READ_UPPER: assert property (s_rdu |=> READ_VALID_OUT &&
    READ_DATA_OUT == $past(UPPER_RESULT_OUT)) else $error("upper read wrong");
  AST_READ_BOTTOM: assert property (s_rdb |=> READ_VALID_OUT &&
    READ_DATA_OUT == $past(BOTTOM_RESULT_OUT)) else $error("bottom read wrong");
  AST_WRITE_UPPER: assert property (s_wru |=>
    UPPER_RESULT_OUT == $past(SOURCE_A_OPERAND_IN) && $stable(BOTTOM_RESULT_OUT))
    else $error("upper write wrong");
  AST_WRITE_BOTTOM: assert property (s_wrb |=>
    BOTTOM_RESULT_OUT == $past(SOURCE_A_OPERAND_IN) && $stable(UPPER_RESULT_OUT))
    else $error("bottom write wrong");
endmodule // muldiv_unit_asserts
bind muldiv_unit muldiv_unit_asserts muldiv_unit_asserts_inst (
  .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .ISSUE_IN(ISSUE_IN), .OP_IN(OP_IN),
  .SOURCE_A_OPERAND_IN(SOURCE_A_OPERAND_IN),
  .SOURCE_B_OPERAND_IN(SOURCE_B_OPERAND_IN), .STALL_OUT(STALL_OUT),
  .READ_VALID_OUT(READ_VALID_OUT), .READ_DATA_OUT(READ_DATA_OUT),
  .UPPER_RESULT_OUT(UPPER_RESULT_OUT), .BOTTOM_RESULT_OUT(BOTTOM_RESULT_OUT));

// ===== sim/pipeline_model.sv
// issuing pipeline model that drives commands and operands
`timescale 1ns/1ps
module pipeline_model (
  input  wire        clk_in,
  output reg         issue_out,
  output reg  [3:0]  op_out,
  output reg  [63:0] a_out,
  output reg  [63:0] b_out
);
  initial {issue_out, op_out, a_out, b_out} = 133'h0;
  // one command held for one edge; word operands sign-extended
  task send(input [3:0] op, input [63:0] a, input [63:0] b);
    issue_out = 1'b1;
    op_out = op;
    a_out = (op < 4'h5) ? {{32{a[31]}}, a[31:0]} : a;
    b_out = (op < 4'h5) ? {{32{b[31]}}, b[31:0]} : b;
    @(posedge clk_in);
    #1;
  endtask
  // released operands show a changing pattern
  task idle;
    {issue_out, op_out, a_out, b_out} = {1'b0, ~op_out, ~a_out, ~b_out};
  endtask
endmodule // pipeline_model

// ===== sim/muldiv_unit_tb.sv
// self-checking bench for the multiply/divide unit
`timescale 1ns/1ps
`include "muldiv_map.vh"
module muldiv_unit_tb;
  reg          clk = 1'b0;
  reg          rst = 1'b1;
  wire         iss, stall, rv;
  wire [3:0]   op;
  wire [63:0]  a, b, rdata, upper, bottom;
  logic [63:0] mu, mb, x, y, s;
  logic [127:0] p;
  int          err_count = 0, checked = 0, cyc = 0, n, w, lt;
  always #10 clk = ~clk;
  pipeline_model pipeline_model_inst (.clk_in(clk), .issue_out(iss),
    .op_out(op), .a_out(a), .b_out(b));
  muldiv_unit muldiv_unit_inst (.CLOCK_IN(clk), .RST_IN(rst), .ISSUE_IN(iss),
    .OP_IN(op), .SOURCE_A_OPERAND_IN(a), .SOURCE_B_OPERAND_IN(b),
    .STALL_OUT(stall), .READ_VALID_OUT(rv), .READ_DATA_OUT(rdata),
    .UPPER_RESULT_OUT(upper), .BOTTOM_RESULT_OUT(bottom));
  function automatic logic [63:0] sx(input logic [31:0] v);
    return {{32{v[31]}}, v};
  endfunction
  task check(input [63:0] got, input [63:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // reference model of the two result registers
  task model(input int o);
    s = {{48{x[15]}}, x[15:0]} * {{48{y[15]}}, y[15:0]};
    case (o)
      1: {mu, mb} = {sx(p[63:32]), sx(p[31:0])};
      2: begin
        s = {32'h0, x[31:0]} * {32'h0, y[31:0]};
        {mu, mb} = {sx(s[63:32]), sx(s[31:0])};
      end
      3, 4: if (y[31:0] == 0) {mu, mb} = {64'h0, sx(x[31:0])};
        else if (o == 3) {mu, mb} = {sx($signed(x[31:0]) % $signed(y[31:0])),
          sx($signed(x[31:0]) / $signed(y[31:0]))};
        else {mu, mb} = {sx(x[31:0] % y[31:0]),
          sx(x[31:0] / y[31:0])};
      5, 6: {mu, mb} = p;
      7, 8: if (y == 0) {mu, mb} = {64'h0, x};
        else if (o == 7) {mu, mb} = {$signed(x) % $signed(y),
          $signed(x) / $signed(y)};
        else {mu, mb} = {x % y, x / y};
      9: begin
        s = {mu[31:0], mb[31:0]} + s;
        {mu, mb} = {sx(s[63:32]), sx(s[31:0])};
      end
      10: mb = mb + s;
      13: mu = x;
      default: mb = x;
    endcase
  endtask
  always @(posedge clk) if (++cyc == 20000) begin err_count++; summarize; end
  initial begin
    n = $urandom(32'hB18AC236);
    {mu, mb} = 128'h0;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    check(upper, mu);
    check({stall, rv, bottom[61:0]}, 64'h0);
    for (int r = 0; r < 3; r++)
      for (int o = 1; o < 15; o++) if (o < 11 || o > 12) begin
      x = {$urandom, $urandom};
      y = (r == 2) ? 64'h0 : {$urandom, $urandom};
      p = {{64{x[63]}}, x} * {{64{y[63]}}, y};
      if (o == 2 || o == 6) p = {64'h0, x} * {64'h0, y};
      if (o == 1) p = sx(x[31:0]) * sx(y[31:0]);
      lt = (o == 3 || o == 4) ? 35 : (o == 5 || o == 6) ? 4 :
           (o == 7 || o == 8) ? 67 : 1;
      pipeline_model_inst.send(4'(o), x, y);
      model(o);
      if (lt == 1) begin
        pipeline_model_inst.idle;
        @(posedge clk);
        #1;
      end
      w = $urandom % 2;
      pipeline_model_inst.send(w ? `OP_READ_UPPER_MOVE : `OP_READ_BOTTOM_MOVE,
                               x, y);
      if (rv !== 1'b1) pipeline_model_inst.idle;
      n = 0;
      while (rv !== 1'b1 && n < 80) begin
        check({63'h0, stall}, 64'h1);
        @(posedge clk);
        #1 n++;
      end
      check({63'h0, stall}, 64'h0);
      check(64'(n), 64'(lt - 1));
      check(rdata, w ? mu : mb);
      check(upper, mu);
      check(bottom, mb);
    end
    // a write during a divide is ignored
    x = 64'h0000_0000_7FFF_FFFF;
    y = 64'h0000_0000_0000_0003;
    pipeline_model_inst.send(`OP_SIGNED_WORD_QUOT, x, y);
    pipeline_model_inst.send(`OP_WRITE_UPPER_MOVE, y, y);
    pipeline_model_inst.idle;
    check(upper, mu);
    model(3);
    repeat (34) @(posedge clk);
    #1 check(upper, mu);
    check(bottom, mb);
    summarize;
  end
endmodule // muldiv_unit_tb
